/* hdl/acr_regs.svh */
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ****************************************************
// widths and counts of the serial readout
// ****************************************************
// result width in bits
`define ACR_RES_W      12
// last bit index of a result word
`define ACR_LAST_BIT   4'hb
// data bits per word on the serial output
`define ACR_WORD_BITS  4'hc
// lowest and highest result codes
`define ACR_CODE_MIN   12'h000
`define ACR_CODE_MAX   12'hfff

// ****************************************************
// reset values
// ****************************************************
// synchroniser stages reset low, chip select included
`define ACR_SYNC_RST   1'h0
// serial output level while released
`define ACR_DOUT_RST   1'h0
// bit counter after reset
`define ACR_CNT_RST    4'h0

`endif

/* hdl/acr_pkg.sv */
`include "acr_regs.svh"

package acr_pkg;
	// one conversion result
	typedef logic [`ACR_RES_W-1:0] acr_word_t;

	// transaction sequencer states
	typedef enum logic [3:0] {
		ACR_IDLE,
		ACR_WAIT_START,
		ACR_MODE,
		ACR_CHAN,
		ACR_ORDER,
		ACR_NULL,
		ACR_MSB,
		ACR_LSB,
		ACR_ZERO
	} acr_state_e;
endpackage

/* hdl/acr_word_if.sv */
`timescale 1ns/1ps

// ****************************************************
// valid/ready word channel between the block's modules
// ****************************************************
interface acr_word_if;
	logic              valid; // word offered
	logic              ready; // word accepted
	acr_pkg::acr_word_t data;  // conversion result

	// side that offers words
	modport source (
		output valid,
		output data,
		input  ready
	);

	// side that takes words
	modport sink (
		input  valid,
		input  data,
		output ready
	);
endinterface

/* hdl/acr_word_buffer.sv */
`timescale 1ns/1ps

// ****************************************************
// two-entry result buffer with flush
// ****************************************************
module acr_word_buffer (
	input  wire logic   clock,
	input  wire logic   reset_n,
	input  wire logic   flush,
	acr_word_if.sink    fill,
	acr_word_if.source  drain
);
	acr_pkg::acr_word_t store [2]; // the two entries
	logic               wr_ptr;    // next entry to fill
	logic               rd_ptr;    // next entry to drain
	logic [1:0]         count;     // entries held
	logic               push;      // accepted on the fill side
	logic               pop;       // taken on the drain side

	// honest full and empty
	assign fill.ready  = (count != 2'h2);
	assign drain.valid = (count != 2'h0);
	assign drain.data  = store[rd_ptr];
	assign push        = fill.valid & fill.ready;
	assign pop         = drain.valid & drain.ready;

	// entry storage, no reset needed on data
	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr] <= fill.data;
		end
	end

	// pointers and fill level; flush drops stale words
	always_ff @(posedge clock) begin
		if (!reset_n || flush) begin
			wr_ptr <= 1'h0;
			rd_ptr <= 1'h0;
			count  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'h0, push} - {1'h0, pop};
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_buf_no_over:  assert property (count != 2'h3)
		else $error("buffer level out of range");
	a_buf_pop_data: assert property (pop && count == 2'h1 && !push |=>
		!drain.valid) else $error("buffer not empty after last pop");
endmodule

/* hdl/acr_serial_adc.sv */
`timescale 1ns/1ps
`include "acr_regs.svh"

// Behaviour
// [RULE1] chip select low opens, high aborts
// [RULE2] host raises chip select between conversions
// [RULE3] low at power-up needs high first
// [RULE4] first clock with input high starts
// [RULE5] leading zero bits are ignored
// [RULE6] mode then channel bit follow start
// [RULE7] mode bit one means single-ended
// [RULE8] channel bit picks input or polarity
// [RULE9] sampling starts second rise after start
// [RULE10] sampling ends third clock's falling edge
// [RULE11] order bit follows channel bit
// [RULE12] null bit driven low on order fall
// [RULE13] twelve result bits, msb first
// [RULE14] output changes only on falling edges
// [RULE15] no repeat: trailing clocks give zeros
// [RULE16] repeat: word again lsb first
// [RULE17] after repeat, zeros without limit
// [RULE18] unsigned code, differential saturates
// [RULE19] output released during configuration bits
// [RULE20] host shifts on fall, samples rise
// [RULE21] host reads word within hold time
// [RULE22] clock may idle low or high
// [RULE23] serial input ignored after order bit
// [RULE24] chip select high resets the sequencer

module acr_serial_adc (
	input  wire logic                clock,
	input  wire logic                reset_n,
	input  wire logic                chip_select_shutdown_n,
	input  wire logic                serial_clock,
	input  wire logic                serial_in,
	output logic                     serial_out,
	output logic                     serial_out_oe,
	input  wire acr_pkg::acr_word_t  analog_input_a,
	input  wire acr_pkg::acr_word_t  analog_input_b,
	output logic                     standby,
	output logic                     sampling
);
	// ****************************************************
	// declarations
	// ****************************************************
	logic [1:0]          cs_sync;    // chip select synchroniser
	logic [1:0]          sclk_sync;  // serial clock synchroniser
	logic                sclk_last;  // previous synced clock
	logic [1:0]          din_sync;   // serial input synchroniser
	acr_pkg::acr_word_t  a_meta;     // input a first stage
	acr_pkg::acr_word_t  a_sync;     // input a second stage
	acr_pkg::acr_word_t  b_meta;     // input b first stage
	acr_pkg::acr_word_t  b_sync;     // input b second stage
	logic                cs_high;    // synced chip select high
	logic                din;        // synced serial input
	logic                sclk_rise;  // one-cycle rising edge
	logic                sclk_fall;  // one-cycle falling edge
	logic                armed;      // high level seen since reset
	acr_pkg::acr_state_e state;      // transaction sequencer
	logic                input_mode_bit;       // 1 single-ended
	logic                chan_bit;             // channel or polarity
	logic                lsb_first_repeat_bit; // repeat requested
	logic [3:0]          bit_cnt;    // result bits sent so far
	acr_pkg::acr_word_t  shreg;      // word being shifted out
	logic                take_word;  // first msb fall pops buffer
	logic                sample_end; // end of sample window

	acr_word_if fill_if ();
	acr_word_if drain_if ();

	// ****************************************************
	// conversion transfer function
	// ****************************************************
	// ideal code; the host's analog model feeds codes directly
	function automatic acr_pkg::acr_word_t convert(
		input logic               mode,
		input logic               chan,
		input acr_pkg::acr_word_t in_a,
		input acr_pkg::acr_word_t in_b
	);
		acr_pkg::acr_word_t pos;
		acr_pkg::acr_word_t neg;
		// [RULE8] channel bit swaps roles
		pos = chan ? in_b : in_a;
		neg = chan ? in_a : in_b;
		// [RULE7] mode picks single-ended
		if (mode) begin
			return pos;
		end
		// [RULE18] clamp below at zero code
		if (pos <= neg) begin
			return `ACR_CODE_MIN;
		end
		// difference never passes the top code
		return pos - neg;
	endfunction

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	// every pin passes two flops; stage two is read, plus sclk_last for clock edges
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cs_sync   <= {2{`ACR_SYNC_RST}};
			sclk_sync <= {2{`ACR_SYNC_RST}};
			sclk_last <= `ACR_SYNC_RST;
			din_sync  <= {2{`ACR_SYNC_RST}};
		end else begin
			cs_sync   <= {cs_sync[0], chip_select_shutdown_n};
			sclk_sync <= {sclk_sync[0], serial_clock};
			sclk_last <= sclk_sync[1];
			din_sync  <= {din_sync[0], serial_in};
		end
	end

	// analog codes, held steady by the source while sampled
	always_ff @(posedge clock) begin
		a_meta <= analog_input_a;
		a_sync <= a_meta;
		b_meta <= analog_input_b;
		b_sync <= b_meta;
	end

	assign cs_high   = cs_sync[1];
	assign din       = din_sync[1];
	// [RULE22] edges work for either idle level
	assign sclk_rise = sclk_sync[1] & ~sclk_last;
	assign sclk_fall = ~sclk_sync[1] & sclk_last;

	// ****************************************************
	// power-up arming and standby
	// ****************************************************
	// [RULE3] arm only after a high level
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			armed <= 1'h0;
		end else if (cs_high) begin
			armed <= 1'h1;
		end
	end

	// [RULE1] chip select high means standby
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			standby <= 1'h1;
		end else begin
			standby <= cs_high | ~armed;
		end
	end

	// ****************************************************
	// transaction sequencer
	// ****************************************************
	// host shifts on falls, so input bits are taken on rises
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= acr_pkg::ACR_IDLE;
		// [RULE24] chip select high restarts sequencer
		end else if (cs_high) begin
			state <= acr_pkg::ACR_IDLE;
		end else begin
			unique case (state)
				// [RULE1] falling chip select opens
				acr_pkg::ACR_IDLE: begin
					if (armed) begin
						state <= acr_pkg::ACR_WAIT_START;
					end
				end
				// [RULE4] first high input bit starts
				// [RULE5] zeros leave the state alone
				acr_pkg::ACR_WAIT_START: begin
					if (sclk_rise && din) begin
						state <= acr_pkg::ACR_MODE;
					end
				end
				acr_pkg::ACR_MODE: begin
					if (sclk_rise) begin
						state <= acr_pkg::ACR_CHAN;
					end
				end
				acr_pkg::ACR_CHAN: begin
					if (sclk_rise) begin
						state <= acr_pkg::ACR_ORDER;
					end
				end
				acr_pkg::ACR_ORDER: begin
					if (sclk_rise) begin
						state <= acr_pkg::ACR_NULL;
					end
				end
				// [RULE12] null bit on order-bit fall
				acr_pkg::ACR_NULL: begin
					if (sclk_fall) begin
						state <= acr_pkg::ACR_MSB;
					end
				end
				// [RULE16] repeat branch after msb word
				acr_pkg::ACR_MSB: begin
					if (sclk_fall && bit_cnt == `ACR_WORD_BITS) begin
						state <= lsb_first_repeat_bit ?
							acr_pkg::ACR_LSB : acr_pkg::ACR_ZERO;
					end
				end
				acr_pkg::ACR_LSB: begin
					if (sclk_fall && bit_cnt == `ACR_WORD_BITS) begin
						state <= acr_pkg::ACR_ZERO;
					end
				end
				// [RULE17] zeros until chip select rises
				acr_pkg::ACR_ZERO: begin
					state <= acr_pkg::ACR_ZERO;
				end
			endcase
		end
	end

	// ****************************************************
	// configuration bits
	// ****************************************************
	// [RULE23] input is sampled only in config states
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			input_mode_bit       <= 1'h0;
			chan_bit             <= 1'h0;
			lsb_first_repeat_bit <= 1'h0;
		end else if (sclk_rise && !cs_high) begin
			if (state == acr_pkg::ACR_MODE) begin
				input_mode_bit <= din;
			end
			if (state == acr_pkg::ACR_CHAN) begin
				chan_bit <= din;
			end
			if (state == acr_pkg::ACR_ORDER) begin
				lsb_first_repeat_bit <= din;
			end
		end
	end

	// ****************************************************
	// sample window and result hand-off
	// ****************************************************
	assign sample_end = (state == acr_pkg::ACR_NULL) & sclk_fall &
		~cs_high;

	// [RULE9] open on the channel-bit rise
	// [RULE10] close on the third clock's fall
	always_ff @(posedge clock) begin
		if (!reset_n || cs_high) begin
			sampling <= 1'h0;
		end else if (state == acr_pkg::ACR_CHAN && sclk_rise) begin
			sampling <= 1'h1;
		end else if (sample_end) begin
			sampling <= 1'h0;
		end
	end

	// held value converted at window close, parked in buffer
	assign fill_if.valid  = sample_end;
	assign fill_if.data   = convert(input_mode_bit, chan_bit,
		a_sync, b_sync);
	assign take_word      = (state == acr_pkg::ACR_MSB) & sclk_fall &
		(bit_cnt == `ACR_CNT_RST) & ~cs_high;
	assign drain_if.ready = take_word;

	acr_word_buffer u_buffer (
		.clock   (clock),
		.reset_n (reset_n),
		.flush   (cs_high),
		.fill    (fill_if.sink),
		.drain   (drain_if.source)
	);

	// ****************************************************
	// serial output
	// ****************************************************
	// bit counter across both word phases
	always_ff @(posedge clock) begin
		if (!reset_n || cs_high) begin
			bit_cnt <= `ACR_CNT_RST;
		end else if (sclk_fall) begin
			if ((state == acr_pkg::ACR_MSB ||
				state == acr_pkg::ACR_LSB) &&
				bit_cnt != `ACR_WORD_BITS) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == acr_pkg::ACR_MSB) begin
				// restart count for the lsb-first copy
				bit_cnt <= 4'h1;
			end
		end
	end

	// held copy of the word for the whole readout
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			shreg <= `ACR_CODE_MIN;
		end else if (take_word) begin
			shreg <= drain_if.data;
		end
	end

	// [RULE14] output moves on falling edges only
	// [RULE19] released until the null bit
	always_ff @(posedge clock) begin
		if (!reset_n || cs_high) begin
			serial_out    <= `ACR_DOUT_RST;
			serial_out_oe <= 1'h0;
		end else if (sclk_fall) begin
			unique case (state)
				// [RULE12] drive the low null bit
				acr_pkg::ACR_NULL: begin
					serial_out    <= 1'h0;
					serial_out_oe <= 1'h1;
				end
				// [RULE13] msb first from the buffer
				acr_pkg::ACR_MSB: begin
					if (bit_cnt == `ACR_CNT_RST) begin
						serial_out <= drain_if.valid &
							drain_if.data[`ACR_LAST_BIT];
					end else if (bit_cnt == `ACR_WORD_BITS) begin
						// [RULE15] zero unless repeat wanted
						// [RULE16] repeat starts with bit zero
						serial_out <= lsb_first_repeat_bit & shreg[0];
					end else begin
						serial_out <= shreg[`ACR_LAST_BIT - bit_cnt];
					end
				end
				// [RULE16] lsb-first copy of the word
				acr_pkg::ACR_LSB: begin
					if (bit_cnt == `ACR_WORD_BITS) begin
						serial_out <= 1'h0;
					end else begin
						serial_out <= shreg[bit_cnt];
					end
				end
				// [RULE17] endless zeros
				acr_pkg::ACR_ZERO: begin
					serial_out <= 1'h0;
				end
				default: begin
					serial_out <= serial_out;
				end
			endcase
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_cs_aborts:     assert property (cs_high |=> // [RULE24]
		state == acr_pkg::ACR_IDLE && !serial_out_oe && !sampling)
		else $error("chip select high did not abort");
	a_powerup_arm:   assert property (!armed |-> // [RULE3]
		state == acr_pkg::ACR_IDLE)
		else $error("transaction opened before arming");
	a_start_zero:    assert property (// [RULE5]
		state == acr_pkg::ACR_WAIT_START && sclk_rise && !din &&
		!cs_high |=> state == acr_pkg::ACR_WAIT_START)
		else $error("leading zero taken as start");
	a_start_taken:   assert property (// [RULE4]
		state == acr_pkg::ACR_WAIT_START && sclk_rise && din &&
		!cs_high |=> state == acr_pkg::ACR_MODE)
		else $error("start bit missed");
	a_out_released:  assert property (// [RULE19]
		state inside {acr_pkg::ACR_WAIT_START, acr_pkg::ACR_MODE,
		acr_pkg::ACR_CHAN, acr_pkg::ACR_ORDER} |-> !serial_out_oe)
		else $error("output driven during configuration");
	a_null_low:      assert property ($rose(serial_out_oe) |-> // [RULE12]
		!serial_out && $past(sclk_fall) &&
		$past(state) == acr_pkg::ACR_NULL)
		else $error("null bit wrong");
	a_out_on_fall:   assert property (// [RULE14]
		serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
		|-> $past(sclk_fall)) else $error("output moved off a fall");
	a_msb_first:     assert property (take_word |=> // [RULE13]
		serial_out == $past(drain_if.data[`ACR_LAST_BIT]))
		else $error("first result bit is not the msb");
	a_zero_tail:     assert property (// [RULE17]
		state == acr_pkg::ACR_ZERO && $past(state) ==
		acr_pkg::ACR_ZERO |-> !serial_out)
		else $error("nonzero after the word");
	a_sample_window: assert property (sampling |-> // [RULE9]
		state inside {acr_pkg::ACR_ORDER, acr_pkg::ACR_NULL})
		else $error("sampling outside its window");
	a_diff_floor:    assert property (// [RULE18]
		fill_if.valid && !input_mode_bit &&
		fill_if.data != `ACR_CODE_MIN |-> (chan_bit ?
		b_sync > a_sync : a_sync > b_sync))
		else $error("differential code not clamped");

	c_msb_only:  cover property (state == acr_pkg::ACR_MSB &&
		!lsb_first_repeat_bit ##1 state == acr_pkg::ACR_ZERO);
	c_lsb_copy:  cover property (state == acr_pkg::ACR_LSB ##1
		state == acr_pkg::ACR_ZERO);
	c_abort_mid: cover property (state == acr_pkg::ACR_MSB &&
		cs_high);
	c_diff_mode: cover property (fill_if.valid && !input_mode_bit);
endmodule

/* testbench/acr_host_model.sv */
`timescale 1ns/1ps

// ****************************************************
// host serial master on the converter's pins
// ****************************************************
module acr_host_model (
	input  wire logic clock,
	input  wire logic serial_out,
	input  wire logic serial_out_oe,
	input  wire logic sampling,
	output logic      chip_select_shutdown_n,
	output logic      serial_clock,
	output logic      serial_in
);
	logic        line;     // level on the data wire
	logic        last_out; // last level the converter drove
	logic [63:0] bit_rise; // wire at each rise, start bit is index 0
	logic [63:0] bit_late; // wire again just before the next fall
	logic [63:0] oe_rise;  // output enable at each rise
	logic [63:0] smp_rise; // sampling flag at each rise

	// chip select already low at power-up
	initial begin
		chip_select_shutdown_n = 1'h0;
		serial_clock           = 1'h0;
		serial_in              = 1'h0;
		last_out               = 1'h0;
	end

	// no pull on the wire: a released line shows the inverse of the
	// last driven level so that a stale bit never passes for data
	always @(posedge clock) begin
		if (serial_out_oe) begin
			last_out <= serial_out;
		end
	end
	assign line = serial_out_oe ? serial_out : ~last_out;

	// ****************************************************
	// one transaction, k counts rises from the start bit
	// ****************************************************
	task automatic xfer(input int lead, input logic mode, chan, order,
		input int rises, input logic cpol, input int half);
		logic b;
		// either idle level of the clock
		serial_clock <= cpol;
		@(posedge clock);
		chip_select_shutdown_n <= 1'h0;
		repeat (6) @(posedge clock);
		for (int k = -lead; k < rises; k++) begin
			// start, mode, channel, order; then ones
			b = (k == 1) ? mode : (k == 2) ? chan :
				(k == 3) ? order : (k >= 0);
			// shift on fall, capture on rise
			serial_clock <= 1'h0;
			serial_in    <= b;
			// half periods far below the hold limit
			repeat (half) @(posedge clock);
			serial_clock <= 1'h1;
			if (k >= 0) begin
				bit_rise[k] = line;
				oe_rise[k]  = serial_out_oe;
				smp_rise[k] = sampling;
			end
			repeat (half) @(posedge clock);
			if (k >= 0) begin
				bit_late[k] = line;
			end
		end
		serial_clock <= cpol;
		repeat (half) @(posedge clock);
		chip_select_shutdown_n <= 1'h1;
		repeat (8) @(posedge clock);
	endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps

// ****************************************************
// self-checking bench for the serial converter
// ****************************************************
module tb;
	localparam int LIMIT = 20000; // cycles before the run is cut short

	logic               clock;   // 10 MHz system clock
	logic               reset_n; // synchronous reset
	acr_pkg::acr_word_t in_a;    // code on input a
	acr_pkg::acr_word_t in_b;    // code on input b
	logic               cs_n;    // chip select pin
	logic               sclk;    // serial clock pin
	logic               din;     // serial data into the converter
	logic               dout;    // serial data out
	logic               oe;      // output enable of dout
	logic               standby; // standby flag
	logic               smp;     // sampling flag
	logic               act_sb;  // standby level while dout is driven
	int                 err_total;
	int                 check_count;
	int                 cycles;
	acr_pkg::acr_word_t w;

	acr_serial_adc DUT (
		.clock                  (clock),
		.reset_n                (reset_n),
		.chip_select_shutdown_n (cs_n),
		.serial_clock           (sclk),
		.serial_in              (din),
		.serial_out             (dout),
		.serial_out_oe          (oe),
		.analog_input_a         (in_a),
		.analog_input_b         (in_b),
		.standby                (standby),
		.sampling               (smp)
	);

	acr_host_model host (
		.clock                  (clock),
		.serial_out             (dout),
		.serial_out_oe          (oe),
		.sampling               (smp),
		.chip_select_shutdown_n (cs_n),
		.serial_clock           (sclk),
		.serial_in              (din)
	);

	// free-running clock, 100 ns period
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	// ****************************************************
	// reporting
	// ****************************************************
	task automatic check(input string what, input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hang guard: a run past the ceiling counts as a mismatch
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			err_total++;
			finish_test();
		end
	end

	// standby must be low whenever the converter drives its output
	always @(posedge clock) begin
		if (oe) begin
			act_sb <= standby;
		end
	end

	// expected code, worked out independently of the design
	function automatic acr_pkg::acr_word_t exp_code(input logic m, c,
		input acr_pkg::acr_word_t a, b);
		acr_pkg::acr_word_t p;
		acr_pkg::acr_word_t n;
		p = c ? b : a;
		n = c ? a : b;
		if (m) begin
			return p;
		end
		return (p > n) ? p - n : 12'h000;
	endfunction

	// ****************************************************
	// full conversion and check of every output bit
	// ****************************************************
	task automatic run(input int lead, input logic m, c, ord, cpol,
		input int half, input acr_pkg::acr_word_t a, b);
		acr_pkg::acr_word_t e;
		e = exp_code(m, c, a, b);
		in_a <= a;
		in_b <= b;
		@(posedge clock);
		host.xfer(lead, m, c, ord, 33, cpol, half);
		check("enable in config", host.oe_rise[3:0], 4'h0);
		check("null bit", {host.oe_rise[4], host.bit_rise[4]}, 2'h2);
		check("sample window", host.smp_rise[4:1], 4'h4);
		for (int j = 0; j < 12; j++) begin
			w[11 - j] = host.bit_rise[5 + j];
		end
		check("msb word", w, e);
		for (int j = 0; j < 12; j++) begin
			w[j] = host.bit_rise[17 + j];
		end
		if (ord) begin
			check("lsb word", w, e);
			check("tail zeros", host.bit_rise[32:29], 4'h0);
		end else begin
			check("tail zeros", host.bit_rise[32:17], 16'h0);
		end
		check("falling edge only", host.bit_late[32:4],
			host.bit_rise[32:4]);
		check("enable after cs high", oe, 1'h0);
		check("standby after cs high", standby, 1'h1);
		check("standby while active", act_sb, 1'h0);
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		reset_n     = 1'h0;
		in_a        = 12'h000;
		in_b        = 12'h000;
		err_total   = 0;
		check_count = 0;
		cycles      = 0;
		repeat (4) @(posedge clock);
		reset_n <= 1'h1;
		repeat (4) @(posedge clock);
		// chip select never seen high yet: no answer expected
		host.xfer(0, 1'h1, 1'h0, 1'h0, 33, 1'h0, 6);
		check("enable while unarmed", host.oe_rise[32:0], 33'h0);
		// every mode, channel, order, idle level, zero count
		for (int i = 0; i < 8; i++) begin
			run(i, i[1], i[0], i[2], i[0] ^ i[2], 6,
				(i < 4) ? 12'hfff : 12'h5a3,
				(i < 4) ? 12'h000 : 12'h1c6);
		end
		// abort in the middle of the msb word, then convert again
		host.xfer(2, 1'h1, 1'h0, 1'h0, 10, 1'h0, 6);
		check("enable after abort", oe, 1'h0);
		run(1, 1'h1, 1'h1, 1'h1, 1'h0, 6, 12'h0f0, 12'ha5a);
		// slow host stalls the read while the result waits
		run(3, 1'h0, 1'h1, 1'h1, 1'h1, 30, 12'h100, 12'h7ff);
		finish_test();
	end
endmodule
